/* cpc_pkg.sv */
// package of register map, field layout and timing constants for the pump control block
package cpc_pkg;
  // control offset 0x020D is not word aligned: kept as index, byte address = 4 * index
  localparam logic [11:0] CPC_CTRL_INDEX = 12'h20D;
  localparam logic [13:0] CPC_CTRL_ADDR = {CPC_CTRL_INDEX, 2'b00};
  localparam logic [13:0] CPC_IRQ_STATUS_ADDR = 14'h0840;
  localparam logic [13:0] CPC_IRQ_CLEAR_ADDR = 14'h0844;
  localparam logic [13:0] CPC_IRQ_ENABLE_ADDR = 14'h0848;
  // control register fields
  localparam int CPC_MODE_HI = 7;
  localparam int CPC_MODE_LO = 6;
  localparam int CPC_OSC_SEL_BIT = 5;
  localparam int CPC_REQ_BIT = 2;
  localparam int CPC_THR_BIT = 1;
  localparam int CPC_RDY_BIT = 0;
  localparam logic [7:0] CPC_CTRL_RESET = 8'h00;
  localparam logic [7:0] CPC_CTRL_WMASK = 8'hE0;
  // interrupt status bits
  localparam int CPC_IRQ_WIDTH = 3;
  localparam int CPC_IRQ_RDY_BIT = 0;
  localparam int CPC_IRQ_THR_FALL_BIT = 1;
  localparam int CPC_IRQ_REQ_BIT = 2;
  localparam logic [2:0] CPC_IRQ_RESET = 3'h0;
  // settle time of the pump before it reports steady state
  localparam int CPC_CLK_MHZ = 50;
  localparam int CPC_SETTLE_US = 10;
  localparam int CPC_SETTLE_CYCLES = CPC_SETTLE_US * CPC_CLK_MHZ;
  localparam int CPC_SETTLE_W = 10;
  // axi responses
  localparam logic [1:0] CPC_RESP_OKAY = 2'h0;
  localparam logic [1:0] CPC_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    CPC_MODE_OFF,
    CPC_MODE_ADC_AUTO,
    CPC_MODE_AUTO,
    CPC_MODE_ON
  } cpc_mode_t;
  typedef enum {
    CPC_ST_OFF,
    CPC_ST_SETTLE,
    CPC_ST_READY
  } cpc_state_t;
endpackage : cpc_pkg

/* cpc_ctrl_if.sv */
// interface carrying pump control between register block and pump sequencer
`timescale 1ns/1ps
`default_nettype none
interface cpc_ctrl_if;
  logic [1:0] mode;
  logic osc_sel;
  logic pump_enable;
  logic settled;
  logic [1:0] clk_source;
  modport regs (output mode, output osc_sel, input pump_enable, input settled, input clk_source);
  modport seq (input mode, input osc_sel, output pump_enable, output settled, output clk_source);
endinterface : cpc_ctrl_if
`default_nettype wire

/* cpc_sequencer.sv */
// pump enable decision, oscillator selection and settle timer
`timescale 1ns/1ps
`default_nettype none
module cpc_sequencer
  import cpc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic supply_above,
  input wire logic converter_on,
  input wire logic conversion_active,
  cpc_ctrl_if.seq ctl
);
  cpc_state_t state;
  cpc_state_t next_state;
  logic [CPC_SETTLE_W-1:0] settle_count;
  logic want_on;

  // mode decode into a pump enable
  always_comb begin
    case (cpc_mode_t'(ctl.mode))
      CPC_MODE_ON: want_on = 1'b1;
      CPC_MODE_AUTO: want_on = ~supply_above;
      CPC_MODE_ADC_AUTO: want_on = converter_on & ~supply_above;
      default: want_on = 1'b0;
    endcase
  end

  // 0 internal pump osc, 1 converter rc osc, 2 divided system osc
  assign ctl.clk_source = ctl.osc_sel ? 2'h0
                        : (conversion_active ? 2'h2 : 2'h1);
  assign ctl.pump_enable = want_on;
  // gated by the decision so ready never lingers a cycle past switch-off
  assign ctl.settled = (state == CPC_ST_READY) && want_on;

  // settle state machine; any switch-off drops ready at once
  always_comb begin
    next_state = state;
    case (state)
      CPC_ST_OFF: if (want_on) next_state = CPC_ST_SETTLE;
      CPC_ST_SETTLE: begin
        if (!want_on) next_state = CPC_ST_OFF;
        else if (settle_count == CPC_SETTLE_W'(CPC_SETTLE_CYCLES - 1)) next_state = CPC_ST_READY;
      end
      CPC_ST_READY: if (!want_on) next_state = CPC_ST_OFF;
      default: next_state = CPC_ST_OFF;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= CPC_ST_OFF;
      settle_count <= '0;
    end else begin
      state <= next_state;
      settle_count <= (state == CPC_ST_SETTLE) ? settle_count + 1'b1 : '0;
    end
  end
endmodule : cpc_sequencer
`default_nettype wire

/* cpc_top.sv */
// charge pump control: axi4-lite registers, input synchronisers and interrupts
//
// Function
// - mode 11 turns the pump on unconditionally
// - mode 10 turns the pump on while supply is below threshold
// - mode 01 compares supply only while a converter is enabled
// - mode resets to 00 and writing 00 turns the pump off
// - oscillator select 1 clocks the pump from its internal oscillator
// - select 0 and conversion idle clocks pump from converter rc oscillator
// - select 0 and conversion active clocks pump from divided system oscillator
// - threshold bit reads 1 above threshold, 0 below, continuously
// - ready bit reads 1 only once the pump has settled
// - request bit reads 1 while an analog peripheral requests the pump
// - control byte: mode 7:6, osc select 5, request 2, threshold 1, ready 0
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cpc_top
  import cpc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [13:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic supply_above_threshold,
  input wire logic converter_on_bit,
  input wire logic converter_conversion_active,
  input wire logic pump_request,
  output logic pump_enable,
  output logic [1:0] pump_clock_select,
  output logic irq
);
  cpc_ctrl_if ctl ();

  // three-stage synchronisers; value taken when stages two and three agree
  logic [2:0] s_thr;
  logic [2:0] s_on;
  logic [2:0] s_go;
  logic [2:0] s_req;
  logic thr;
  logic conv_on;
  logic conv_go;
  logic req;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_thr <= 3'h0;
      s_on <= 3'h0;
      s_go <= 3'h0;
      s_req <= 3'h0;
      thr <= 1'b0;
      conv_on <= 1'b0;
      conv_go <= 1'b0;
      req <= 1'b0;
    end else begin
      s_thr <= {s_thr[1:0], supply_above_threshold};
      s_on <= {s_on[1:0], converter_on_bit};
      s_go <= {s_go[1:0], converter_conversion_active};
      s_req <= {s_req[1:0], pump_request};
      if (s_thr[2] == s_thr[1]) thr <= s_thr[2];
      if (s_on[2] == s_on[1]) conv_on <= s_on[2];
      if (s_go[2] == s_go[1]) conv_go <= s_go[2];
      if (s_req[2] == s_req[1]) req <= s_req[2];
    end
  end

  cpc_sequencer u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .supply_above(thr),
    .converter_on(conv_on),
    .conversion_active(conv_go),
    .ctl(ctl.seq)
  );

  // software state
  logic [1:0] mode;
  logic osc_sel;
  logic [CPC_IRQ_WIDTH-1:0] irq_status;
  logic [CPC_IRQ_WIDTH-1:0] irq_enable;
  assign ctl.mode = mode;
  assign ctl.osc_sel = osc_sel;

  // write channel: address and data caught independently, any order
  logic aw_held;
  logic w_held;
  logic [13:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_ctrl = do_write && (aw_addr == CPC_CTRL_ADDR);
  wire wr_clear = do_write && (aw_addr == CPC_IRQ_CLEAR_ADDR);
  wire wr_enable = do_write && (aw_addr == CPC_IRQ_ENABLE_ADDR);
  wire wr_status = do_write && (aw_addr == CPC_IRQ_STATUS_ADDR);
  wire wr_known = wr_ctrl || wr_clear || wr_enable || wr_status;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 14'h0000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CPC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[13:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? CPC_RESP_OKAY : CPC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control fields; only lane 0 and bits 7:5 are writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= CPC_CTRL_RESET[CPC_MODE_HI:CPC_MODE_LO];
      osc_sel <= CPC_CTRL_RESET[CPC_OSC_SEL_BIT];
      irq_enable <= CPC_IRQ_RESET;
    end else begin
      if (wr_ctrl && w_strb[0]) begin
        mode <= w_data[CPC_MODE_HI:CPC_MODE_LO];
        osc_sel <= w_data[CPC_OSC_SEL_BIT];
      end
      if (wr_enable && w_strb[0]) irq_enable <= w_data[CPC_IRQ_WIDTH-1:0];
    end
  end

  // events: pump became ready, supply fell below threshold, new request
  logic rdy_d;
  logic thr_d;
  logic req_d;
  logic [CPC_IRQ_WIDTH-1:0] events;
  logic [CPC_IRQ_WIDTH-1:0] clr_bits;
  assign events[CPC_IRQ_RDY_BIT] = ctl.settled && !rdy_d;
  assign events[CPC_IRQ_THR_FALL_BIT] = !thr && thr_d;
  assign events[CPC_IRQ_REQ_BIT] = req && !req_d;
  assign clr_bits = (wr_clear && w_strb[0]) ? w_data[CPC_IRQ_WIDTH-1:0] : '0;

  // set wins over clear so an event in the clearing cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdy_d <= 1'b0;
      thr_d <= 1'b0;
      req_d <= 1'b0;
      irq_status <= CPC_IRQ_RESET;
    end else begin
      rdy_d <= ctl.settled;
      thr_d <= thr;
      req_d <= req;
      irq_status <= (irq_status & ~clr_bits) | events;
    end
  end

  // read path: one register stage, address decoded by if chain
  logic [7:0] ctrl_view;
  assign ctrl_view = {mode, osc_sel, 2'b00, req, thr, ctl.settled};
  logic [31:0] rd_value;
  logic rd_known;
  always_comb begin
    rd_value = 32'h00000000;
    rd_known = 1'b1;
    if (s_axi_araddr[13:2] == CPC_CTRL_INDEX) begin
      rd_value = {24'h000000, ctrl_view};
    end else if ({s_axi_araddr[13:2], 2'b00} == CPC_IRQ_STATUS_ADDR) begin
      rd_value = {29'h00000000, irq_status};
    end else if ({s_axi_araddr[13:2], 2'b00} == CPC_IRQ_ENABLE_ADDR) begin
      rd_value = {29'h00000000, irq_enable};
    end else if ({s_axi_araddr[13:2], 2'b00} == CPC_IRQ_CLEAR_ADDR) begin
      rd_value = 32'h00000000;
    end else begin
      rd_known = 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= CPC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= rd_known ? CPC_RESP_OKAY : CPC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // outputs to the analog pump
  assign pump_enable = ctl.pump_enable;
  assign pump_clock_select = ctl.clk_source;
  assign irq = |(irq_status & irq_enable);
endmodule : cpc_top
`default_nettype wire

/* cpc_top_props.sv */
// checker of handshakes, clock selection and status read-back
`timescale 1ns/1ps
`default_nettype none
module cpc_top_props
  import cpc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic supply_above_threshold,
  input wire logic converter_conversion_active,
  input wire logic pump_enable,
  input wire logic [1:0] pump_clock_select
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [13:0] rd_addr;
  // address of the read under way, so data can be judged per register
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
  end
  sequence ctrl_read;
    s_axi_rvalid && rd_addr == CPC_CTRL_ADDR;
  endsequence
  // inputs pass three flops and an agree stage, so eight stable cycles
  sequence conv_hi;
    converter_conversion_active [*8];
  endsequence
  sequence conv_lo;
    !converter_conversion_active [*8];
  endsequence
  AST_R_NEXT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  AST_RST_OFF: assert property ($rose(aresetn) |-> !pump_enable)
    else $error("pump on after reset");
  AST_SEL_LEGAL: assert property (pump_clock_select != 2'h3)
    else $error("bad clock source");
  AST_SEL_RC: assert property (conv_lo ##0 pump_clock_select != 2'h0 |-> pump_clock_select == 2'h1)
    else $error("rc source expected");
  AST_SEL_SYS: assert property (conv_hi ##0 pump_clock_select != 2'h0 |-> pump_clock_select == 2'h2)
    else $error("system source expected");
  AST_THR_HI: assert property (supply_above_threshold [*8] ##0 ctrl_read |-> s_axi_rdata[1])
    else $error("threshold bit low");
  AST_RD_ZERO: assert property (ctrl_read |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[4:3] == 2'h0)
    else $error("unused bits set");
endmodule : cpc_top_props
bind cpc_top cpc_top_props u_props (.*);
`default_nettype wire

/* cpc_analog_model.sv */
// analog side: supply comparator, converter and pump request
`timescale 1ns/1ps
`default_nettype none
module cpc_analog_model (
  input wire logic [3:0] cmd,
  output logic supply_above_threshold,
  output logic converter_on_bit,
  output logic converter_conversion_active,
  output logic pump_request
);
  // a conversion only runs while the converter is on
  assign supply_above_threshold = cmd[0];
  assign converter_on_bit = cmd[1];
  assign converter_conversion_active = cmd[2] & cmd[1];
  assign pump_request = cmd[3];
endmodule : cpc_analog_model
`default_nettype wire

/* cpc_top_test.sv */
// self-checking bench of the pump control block
`timescale 1ns/1ps
`default_nettype none
module cpc_top_test
  import cpc_pkg::*;
;
  localparam logic [13:0] CA = CPC_CTRL_ADDR;
  localparam logic [1:0] OK = CPC_RESP_OKAY;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, cmd;
  logic [1:0] s_axi_bresp, s_axi_rresp, pump_clock_select;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pump_enable, irq;
  logic supply_above_threshold, converter_on_bit, converter_conversion_active, pump_request;
  int num_errors = 0;
  int comparisons = 0;
  cpc_top dut (.*);
  cpc_analog_model u_analog (.*);
  always #10 aclk = ~aclk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [13:0] a, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk("bresp", er, s_axi_bresp);
  endtask : wr
  task automatic rc(input logic [13:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk("rdata", e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask : rc
  // every mode against every supply and converter state
  task automatic t_modes();
    logic [1:0] m;
    logic c, s;
    for (int i = 0; i < 16; i++) begin
      {m, c, s} = i[3:0];
      cmd <= {2'b00, c, s};
      wr(CA, {m, 6'h00}, OK);
      cyc(6);
      chk("pump_enable", m == 2'h3 || (m == 2'h2 && !s) || (m == 2'h1 && !s && c), pump_enable);
      rc(CA, {m, 4'h0, s, 1'b0}, OK);
    end
  endtask : t_modes
  task automatic t_osc();
    cmd <= 4'h7;
    wr(CA, 8'h20, OK);
    cyc(8);
    chk("pump_enable", 1'b0, pump_enable);
    chk("clock select", 2'h0, pump_clock_select);
    wr(CA, 8'h00, OK);
    cyc(2);
    chk("clock select", 2'h2, pump_clock_select);
    cmd <= 4'h3;
    cyc(8);
    chk("clock select", 2'h1, pump_clock_select);
  endtask : t_osc
  // settle, then raise, mask and clear the ready interrupt
  task automatic t_ready();
    wr(CPC_IRQ_CLEAR_ADDR, 8'h07, OK);
    wr(CPC_IRQ_ENABLE_ADDR, 8'h01, OK);
    wr(CA, 8'hC0, OK);
    rc(CA, 32'hC2, OK);
    chk("irq", 1'b0, irq);
    cyc(CPC_SETTLE_CYCLES + 10);
    rc(CA, 32'hC3, OK);
    chk("irq", 1'b1, irq);
    wr(CPC_IRQ_ENABLE_ADDR, 8'h00, OK);
    chk("irq", 1'b0, irq);
    wr(CPC_IRQ_ENABLE_ADDR, 8'h01, OK);
    chk("irq", 1'b1, irq);
    wr(CPC_IRQ_CLEAR_ADDR, 8'h01, OK);
    chk("irq", 1'b0, irq);
    wr(CA, 8'h00, OK);
    rc(CA, 32'h02, OK);
  endtask : t_ready
  task automatic t_regs();
    cmd <= 4'hB;
    cyc(6);
    wr(CA, 8'hFF, OK);
    rc(CA, 32'hE6, OK);
    rc(CPC_IRQ_STATUS_ADDR, 32'h4, OK);
    rc(CPC_IRQ_CLEAR_ADDR, 32'h0, OK);
    wr(14'h0100, 8'h5A, CPC_RESP_SLVERR);
    rc(14'h0100, 32'h0, CPC_RESP_SLVERR);
    // late acceptance: the write answer must stand until bready
    s_axi_bready <= 1'b0;
    wr(CPC_IRQ_ENABLE_ADDR, 8'h00, OK);
    cyc(3);
    chk("bvalid", 1'b1, s_axi_bvalid);
    s_axi_bready <= 1'b1;
    cyc(2);
    chk("bvalid", 1'b0, s_axi_bvalid);
  endtask : t_regs
  // reset in mid-run after mode 11 was written
  task automatic t_reset();
    aresetn <= 1'b0;
    cyc(10);
    aresetn <= 1'b1;
    cyc(6);
    chk("pump_enable", 1'b0, pump_enable);
    rc(CA, 32'h06, OK);
  endtask : t_reset
  task automatic results();
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  // main sequence; responses are accepted at once except in the late-acceptance check of t_regs
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    s_axi_wstrb = 4'hF;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    cmd = 4'h1;
    cyc(10);
    aresetn <= 1'b1;
    cyc(6);
    rc(CA, 32'h02, OK);
    rc(CPC_IRQ_ENABLE_ADDR, 32'h0, OK);
    t_modes();
    t_osc();
    t_ready();
    t_regs();
    t_reset();
    results();
  end
  // hang guard, well past the longest run
  initial begin
    cyc(20000);
    num_errors++;
    results();
  end
endmodule : cpc_top_test
`default_nettype wire
